// ### bench/reset_and_stop_recovery_ctrl_tb_top.sv
// self-checking bench for the reset and stop recovery controller
// assumes rsrc_env drives the sources; apb master is this module
`timescale 1ns/1ps
module reset_and_stop_recovery_ctrl_tb_top;
   typedef struct {logic rd; logic err; logic [31:0] d; logic [31:0] m;} rsrc_exp_s;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, per;
   logic        cpu_reset, periph_reset, sys_clk_en, stop_mode, por, bo, wd, xn, flt;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, v;
   logic [7:0]  gpio_in, gpio_smr_en;
   rsrc_exp_s   exp_q[$];
   rsrc_exp_s   e;
   int          miscompares, num_checks, p;
   rsrc_env env (.pclk(pclk), .por_det(por), .brownout_detect(bo), .watchdog_timeout(wd),
      .ext_reset_n(xn), .fault_detect(flt), .gpio_in(gpio_in));
   rsrc_ctrl uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .por_det(por), .brownout_detect(bo), .watchdog_timeout(wd),
      .ext_reset_n(xn), .fault_detect(flt), .gpio_in(gpio_in), .gpio_smr_en(gpio_smr_en),
      .cpu_reset(cpu_reset), .periph_reset(periph_reset), .sys_clk_en(sys_clk_en),
      .stop_mode(stop_mode));
   always #50 pclk = ~pclk;
   task automatic conclude;
      if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      num_checks++;
      if (s !== x) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", nm, x, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic err);
      int n = 0;
      @(posedge pclk);
      exp_q.push_back('{!w, err, d, m});
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      {psel, penable} <= 2'b00;
      if (pready !== 1'b1) begin
         miscompares++;
         conclude();
      end
   endtask : apb
   // sees the reset go up, then times its phases
   task automatic measure;
      int n = 0, hold = 0, sys = 0;
      per = 1'b0;
      while (cpu_reset !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      // counts only edges at which the cpu is still held
      while (cpu_reset === 1'b1 && hold < 400) begin
         hold++;
         sys += (sys_clk_en === 1'b1);
         per |= (periph_reset === 1'b1);
         @(posedge pclk);
      end
      chk("hold", hold >= rsrc_pkg::MIN_HOLD_CYC && hold < 400, 1);
      chk("sys", sys >= rsrc_pkg::SYS_PHASE_CYC && hold >= sys + 50, 1);
   endtask : measure
   task automatic quiet;
      int c = 0;
      repeat (14) begin
         @(posedge pclk);
         c += (cpu_reset !== 1'b0);
      end
      chk("quiet", c, 0);
   endtask : quiet
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         chk("pslverr", {31'h0, pslverr}, {31'h0, e.err});
         if (e.rd) chk("prdata", prdata & e.m, e.d & e.m);
      end
   end
   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      gpio_smr_en = 8'h00;
      void'($urandom(32'hA0ACBB96));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      measure();
      apb(0, rsrc_pkg::OFF_CTRL, 32'h1, '1, 0);
      apb(0, rsrc_pkg::OFF_STATUS, 32'h1, '1, 0);
      apb(0, rsrc_pkg::OFF_OSC, 32'hA0, '1, 0);
      apb(0, rsrc_pkg::OFF_DBG, 32'h0, '1, 0);
      apb(0, 12'h010, 32'h0, 32'h0, 1);
      for (int s = 0; s < 5; s++) begin
         v = 32'($urandom_range(255));
         apb(1, rsrc_pkg::OFF_OSC, v, '1, 0);
         apb(0, rsrc_pkg::OFF_OSC, v, '1, 0);
         fork
            if (s < 4) env.fire(s + 1);
            else apb(1, rsrc_pkg::OFF_DBG, 32'h1, '1, 0);
            measure();
         join
         chk("periph", per, 1);
         p = s == 0 ? 0 : s == 1 ? 1 : s == 2 ? 2 : s == 3 ? 4 : 3;
         apb(0, rsrc_pkg::OFF_STATUS, 32'h1 << p, '1, 0);
         apb(0, rsrc_pkg::OFF_OSC, 32'hA0, '1, 0);
      end
      apb(1, rsrc_pkg::OFF_CTRL, 32'h0, '1, 0);
      env.fire(2);
      quiet();
      apb(1, rsrc_pkg::OFF_CTRL, 32'h2, '1, 0);
      @(posedge pclk);
      chk("stop", stop_mode, 1);
      p = $urandom_range(7);
      env.toggle(p);
      quiet();
      gpio_smr_en <= 8'h01 << p;
      for (int s = 0; s < 2; s++) begin
         apb(1, rsrc_pkg::OFF_OSC, 32'h5A, '1, 0);
         apb(1, rsrc_pkg::OFF_CTRL, 32'h2, '1, 0);
         fork
            if (s == 0) env.toggle(p);
            else env.fire(2);
            measure();
         join
         chk("periph", per, 0);
         apb(0, rsrc_pkg::OFF_STATUS, 32'h60, 32'h60, 0);
         apb(0, rsrc_pkg::OFF_OSC, 32'hA0, '1, 0);
         apb(0, rsrc_pkg::OFF_CTRL, 32'h0, '1, 0);
      end
      apb(1, rsrc_pkg::OFF_CTRL, 32'h3, '1, 0);
      fork
         env.fire(5);
         measure();
      join
      chk("periph", per, 1);
      apb(0, rsrc_pkg::OFF_STATUS, 32'h1, 32'h1, 0);
      apb(0, rsrc_pkg::OFF_CTRL, 32'h1, '1, 0);
      repeat (3) @(posedge pclk);
      conclude();
   end
endmodule : reset_and_stop_recovery_ctrl_tb_top

// ### bench/rsrc_env.sv
// far-side model: supply monitors, watchdog, reset pin, fault logic, gpio pins
// assumes the bench clock; levels change just after a rising edge
`timescale 1ns/1ps
module rsrc_env (
   // clock
   input  wire logic pclk,
   // request levels
   output logic       por_det,
   output logic       brownout_detect,
   output logic       watchdog_timeout,
   output logic       ext_reset_n,
   output logic       fault_detect,
   output logic [7:0] gpio_in
);
   initial begin
      {por_det, brownout_detect, watchdog_timeout, fault_detect} = 4'h0;
      ext_reset_n = 1'b1;
      gpio_in     = 8'hA5;
   end
   // 1 brownout, 2 watchdog, 3 pin, 4 fault, 5 power-on with pin
   task automatic fire(input int src);
      @(posedge pclk);
      brownout_detect  <= (src == 1);
      watchdog_timeout <= (src == 2);
      ext_reset_n      <= !(src == 3 || src == 5);
      fault_detect     <= (src == 4);
      por_det          <= (src == 5);
      repeat (6) @(posedge pclk);
      {por_det, brownout_detect, watchdog_timeout, fault_detect} <= 4'h0;
      ext_reset_n <= 1'b1;
   endtask : fire
   task automatic toggle(input int p);
      @(posedge pclk);
      gpio_in[p] <= ~gpio_in[p];
   endtask : toggle
endmodule : rsrc_env

// ### design/rsrc_ctrl.sv
// reset and stop mode recovery controller with an APB register slave
// assumes event inputs are asynchronous levels; debugger write arrives over APB
`timescale 1ns/1ps
module rsrc_ctrl (
   // clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // reset sources
   input  wire logic        por_det,
   input  wire logic        brownout_detect,
   input  wire logic        watchdog_timeout,
   input  wire logic        ext_reset_n,
   input  wire logic        fault_detect,
   input  wire logic [7:0]  gpio_in,
   input  wire logic [7:0]  gpio_smr_en,
   // reset outputs
   output logic             cpu_reset,
   output logic             periph_reset,
   output logic             sys_clk_en,
   output logic             stop_mode
);
   logic [5:0] sync_q;
   logic [7:0] gpio_s;
   logic [7:0] gpio_d;
   logic       por_s, bo_s, wdt_s, extn_s, flt_s, wdt_d;
   logic       reset_on_watchdog_option;
   logic [6:0] status;
   logic [7:0] oscillator_control_reg;
   logic       dbg_req;
   logic       sys_req, smr_req, is_sys;
   logic [6:0] cnt;
   logic [6:0] hold_cnt;
   logic [6:0] sys_hold;
   logic [6:0] next_cause;
   rsrc_pkg::rsrc_state_e state;

   rsrc_sync #(.W(6)) u_sync (
      .pclk   (pclk),
      .presetn(presetn),
      .ce     (ce),
      .d      ({por_det, brownout_detect, watchdog_timeout, ~ext_reset_n, fault_detect, 1'b0}),
      .q      (sync_q)
   );
   rsrc_sync #(.W(8)) u_gsync (
      .pclk   (pclk),
      .presetn(presetn),
      .ce     (ce),
      .d      (gpio_in),
      .q      (gpio_s)
   );
   assign {por_s, bo_s, wdt_s, extn_s, flt_s} = sync_q[5:1];

   wire wr_acc = psel && penable && pwrite && pready;
   wire wdt_edge = wdt_s && !wdt_d;
   wire gpio_hit = |((gpio_s ^ gpio_d) & gpio_smr_en);
   assign dbg_req = wr_acc && paddr == rsrc_pkg::OFF_DBG && pwdata[0];
   wire busy = state != rsrc_pkg::RSRC_RUN;

   // source arbitration and type selection
   always_comb begin
      sys_req    = 1'b0;
      smr_req    = 1'b0;
      next_cause = '0;
      if (por_s || bo_s) begin
         sys_req = 1'b1;
         next_cause[rsrc_pkg::ST_POR] = 1'b1;
      end else if (extn_s || flt_s) begin
         sys_req = 1'b1;
         next_cause[rsrc_pkg::ST_EXT] = extn_s;
         next_cause[rsrc_pkg::ST_FLT] = flt_s;
      end else if (stop_mode) begin
         if (wdt_edge || gpio_hit) begin
            smr_req = 1'b1;
            next_cause[rsrc_pkg::ST_WDT] = wdt_edge;
            next_cause[rsrc_pkg::ST_SMR] = 1'b1;
            next_cause[rsrc_pkg::ST_STOP] = 1'b1;
         end
      end else if (wdt_edge && reset_on_watchdog_option) begin
         sys_req = 1'b1;
         next_cause[rsrc_pkg::ST_WDT] = 1'b1;
      end else if (dbg_req) begin
         sys_req = 1'b1;
         next_cause[rsrc_pkg::ST_DBG] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_d  <= 1'b0;
         gpio_d <= '0;
      end else if (ce) begin
         wdt_d  <= wdt_s;
         gpio_d <= gpio_s;
      end
   end

   // sequencer: two types only, both run the same oscillator and system clock phase counts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state        <= rsrc_pkg::RSRC_OSC;
         cnt          <= '0;
         is_sys       <= 1'b1;
         cpu_reset    <= 1'b1;
         periph_reset <= 1'b1;
         sys_clk_en   <= 1'b0;
      end else if (ce) begin
         case (state)
            rsrc_pkg::RSRC_RUN: begin
               if (sys_req || smr_req) begin
                  state        <= rsrc_pkg::RSRC_OSC;
                  cnt          <= '0;
                  is_sys       <= sys_req;
                  cpu_reset    <= 1'b1;
                  periph_reset <= sys_req;
                  sys_clk_en   <= 1'b0;
               end
            end
            rsrc_pkg::RSRC_OSC: begin
               if (por_s || bo_s) begin
                  cnt <= '0;
               end else if (cnt == rsrc_pkg::OSC_LAST) begin
                  state      <= rsrc_pkg::RSRC_SYS;
                  cnt        <= '0;
                  sys_clk_en <= 1'b1;
               end else begin
                  cnt <= cnt + 7'h01;
               end
            end
            rsrc_pkg::RSRC_SYS: begin
               if (por_s || bo_s) begin
                  state      <= rsrc_pkg::RSRC_OSC;
                  cnt        <= '0;
                  is_sys     <= 1'b1;
                  periph_reset <= 1'b1;
                  sys_clk_en <= 1'b0;
               end else if (extn_s) begin
                  cnt <= '0;
               end else if (cnt == rsrc_pkg::SYS_LAST) begin
                  state        <= rsrc_pkg::RSRC_RUN;
                  cpu_reset    <= 1'b0;
                  periph_reset <= 1'b0;
               end else begin
                  cnt <= cnt + 7'h01;
               end
            end
            default: state <= rsrc_pkg::RSRC_OSC;
         endcase
      end
   end

   // registers; system reset restores them, stop recovery clears stop and restores the oscillator but keeps the watchdog option
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_on_watchdog_option <= 1'b1;
         stop_mode                <= 1'b0;
         oscillator_control_reg   <= rsrc_pkg::OSC_RESET;
      end else if (ce) begin
         if (sys_req && !busy) begin
            reset_on_watchdog_option <= 1'b1;
            stop_mode                <= 1'b0;
            oscillator_control_reg   <= rsrc_pkg::OSC_RESET;
         end else if (smr_req && !busy) begin
            stop_mode              <= 1'b0;
            oscillator_control_reg <= rsrc_pkg::OSC_RESET;
         end else if (wr_acc && !busy) begin
            if (paddr == rsrc_pkg::OFF_CTRL) begin
               reset_on_watchdog_option <= pwdata[rsrc_pkg::CTRL_RESET_ON_WATCHDOG_OPTION];
               stop_mode                <= pwdata[rsrc_pkg::CTRL_STOP];
            end else if (paddr == rsrc_pkg::OFF_OSC) begin
               oscillator_control_reg <= pwdata[7:0];
            end
         end
      end
   end

   // cause record, power-on value at async reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= 7'h01;
      end else if (ce) begin
         if ((sys_req || smr_req) && !busy) begin
            status <= next_cause;
         end else if ((por_s || bo_s) && busy) begin
            status <= 7'h01;
         end
      end
   end

   // apb read path, zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         prdata  <= '0;
         if (psel && !penable) begin
            if (paddr == rsrc_pkg::OFF_CTRL) begin
               prdata <= {30'h0, stop_mode, reset_on_watchdog_option};
            end else if (paddr == rsrc_pkg::OFF_STATUS) begin
               prdata <= {25'h0, status};
            end else if (paddr == rsrc_pkg::OFF_DBG) begin
               prdata <= '0;
            end else if (paddr == rsrc_pkg::OFF_OSC) begin
               prdata <= {24'h0, oscillator_control_reg};
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end

   // hold length checks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_cnt <= '0;
         sys_hold <= '0;
      end else if (ce) begin
         hold_cnt <= cpu_reset ? ((hold_cnt == 7'h7F) ? hold_cnt : hold_cnt + 7'h01) : 7'h00;
         // cycles with system clock running and cpu still held
         if (cpu_reset && sys_clk_en) begin
            sys_hold <= (sys_hold == 7'h7F) ? sys_hold : sys_hold + 7'h01;
         end else begin
            sys_hold <= 7'h00;
         end
      end
   end

   min_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(cpu_reset) |-> $past(hold_cnt) >= 7'(rsrc_pkg::MIN_HOLD_CYC - 1))
      else $error("cpu released too early");
   clk_phase_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(cpu_reset) |-> sys_hold >= 7'(rsrc_pkg::SYS_PHASE_CYC))
      else $error("cpu released within 16 system cycles");
   por_wins_a: assert property (@(posedge pclk) disable iff (!presetn || !ce)
      (por_s && !busy) |=> is_sys && periph_reset)
      else $error("power-on did not give system reset");
   wdt_gate_a: assert property (@(posedge pclk) disable iff (!presetn || !ce)
      (!busy && !stop_mode && wdt_edge && !reset_on_watchdog_option && !por_s && !bo_s
       && !extn_s && !flt_s && !dbg_req) |=> !cpu_reset)
      else $error("watchdog reset while option clear");
   dbg_reset_a: assert property (@(posedge pclk) disable iff (!presetn || !ce)
      (!busy && !stop_mode && dbg_req) |=> cpu_reset && is_sys)
      else $error("debug write did not reset");
   smr_keep_a: assert property (@(posedge pclk) disable iff (!presetn || !ce)
      (!busy && smr_req && !sys_req) |=> !periph_reset && !is_sys)
      else $error("stop recovery touched peripherals");
   stop_src_a: assert property (@(posedge pclk) disable iff (!presetn || !ce)
      (!busy && stop_mode && gpio_hit && !por_s && !bo_s && !extn_s && !flt_s)
      |=> cpu_reset && !is_sys)
      else $error("gpio wake did not recover");
   cause_rec_a: assert property (@(posedge pclk) disable iff (!presetn || !ce)
      (!busy && (sys_req || smr_req)) |=> status == $past(next_cause))
      else $error("cause not recorded");
   sys_reset_c: cover property (@(posedge pclk) disable iff (!presetn) $fell(cpu_reset) && is_sys);
   smr_c: cover property (@(posedge pclk) disable iff (!presetn) $fell(cpu_reset) && !is_sys);
   dbg_c: cover property (@(posedge pclk) disable iff (!presetn) dbg_req && !busy);
endmodule : rsrc_ctrl

// ### design/rsrc_pkg.sv
// constants for the reset and stop recovery controller
// assumes a 10 MHz pclk that also stands for the oscillator cycle count
package rsrc_pkg;
   // register byte offsets
   localparam logic [11:0] OFF_CTRL   = 12'h000;
   localparam logic [11:0] OFF_STATUS = 12'h004;
   localparam logic [11:0] OFF_DBG    = 12'h008;
   localparam logic [11:0] OFF_OSC    = 12'h00C;
   // control fields
   localparam int CTRL_RESET_ON_WATCHDOG_OPTION = 0;
   localparam int CTRL_STOP    = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;
   // status bits
   localparam int ST_POR  = 0;
   localparam int ST_WDT  = 1;
   localparam int ST_EXT  = 2;
   localparam int ST_DBG  = 3;
   localparam int ST_FLT  = 4;
   localparam int ST_STOP = 5;
   localparam int ST_SMR  = 6;
   localparam logic [7:0] OSC_RESET = 8'hA0;
   // reset sequence lengths
   localparam int OSC_PHASE_CYC = 50;
   localparam int SYS_PHASE_CYC = 16;
   localparam int MIN_HOLD_CYC  = 66;
   localparam logic [6:0] OSC_LAST = 7'(OSC_PHASE_CYC - 1);
   localparam logic [6:0] SYS_LAST = 7'(SYS_PHASE_CYC - 1);
   typedef enum logic [1:0] {
      RSRC_RUN  = 2'b00,
      RSRC_OSC  = 2'b01,
      RSRC_SYS  = 2'b10
   } rsrc_state_e;
endpackage : rsrc_pkg

// ### design/rsrc_sync.sv
// two-stage synchroniser for asynchronous level inputs
// assumes pclk domain, async active-low reset
`timescale 1ns/1ps
module rsrc_sync #(parameter int W = 1) (
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   // data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '0;
         q    <= '0;
      end else if (ce) begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : rsrc_sync
